// file: include/pcs_pkg.sv
// pcs_pkg: constants and carriers for the function-three config block
// assumes config cycles arrive already decoded to a register offset
package pcs_pkg;

  // config register byte offsets
  localparam logic [7:0] OFS_LINE_LAT  = 8'h0C;
  localparam logic [7:0] OFS_BASE0     = 8'h10;
  localparam logic [7:0] OFS_SUBSYS    = 8'h2C;
  localparam logic [7:0] OFS_FIRST_CAPABILITY_OFFSET   = 8'h34;
  localparam logic [7:0] OFS_INT_LAT   = 8'h3C;
  localparam logic [7:0] OFS_DEV_CTRL  = 8'h40;
  localparam logic [7:0] OFS_PD_CAP    = 8'h44;
  localparam logic [7:0] OFS_PD_WORD   = 8'h48;
  localparam logic [7:0] OFS_PWR_CAP   = 8'h4C;
  localparam logic [7:0] OFS_PWR_CTRL  = 8'h50;

  // fixed field values
  localparam logic [2:0]  FUNC_NUMBER      = 3'b011;
  localparam logic [7:0]  HEADER_LAYOUT    = 8'h80;
  localparam logic [7:0]  SELF_TEST_CODE   = 8'h00;
  localparam logic [7:0]  FIRST_CAP_OFS    = 8'h44;
  localparam logic [7:0]  MAX_LATENCY_HINT_HINT     = 8'hFF;
  localparam logic [7:0]  MIN_GRANT_HINT   = 8'h06;
  localparam logic [7:0]  INT_PIN_CODE     = 8'h01;
  localparam logic [7:0]  PD_CAP_CODE      = 8'h03;
  localparam logic [7:0]  PD_NEXT_OFS      = 8'h4C;
  localparam logic [7:0]  PWR_CAP_CODE     = 8'h01;
  localparam logic [7:0]  PWR_NEXT_OFS     = 8'h00;
  localparam logic [2:0]  PWR_SPEC_VER     = 3'b010;
  localparam logic [1:0]  PWR_D0           = 2'b00;
  localparam logic [1:0]  PWR_D3HOT        = 2'b11;

  // reset values
  localparam logic [2:0]  RETRY_LIMIT_RST  = 3'b011;
  localparam logic [4:0]  READY_ON_RST     = 5'b1_1111;
  localparam logic [3:0]  FUNC_EN_RST      = 4'b1111;

  // eeprom byte addresses loaded after reset, and last byte index of each sequence
  localparam logic [14:0] EE_BOARD_MAKER   = 15'h0004;
  localparam logic [14:0] EE_FUNC_ENABLE   = 15'h0008;
  localparam logic [2:0]  BOOT_LAST_IDX    = 3'd4;
  localparam logic [2:0]  WORD_LAST_IDX    = 3'd3;

  // one configuration access
  typedef struct packed {
    logic        valid;
    logic        type0;
    logic [2:0]  func;
    logic [7:0]  offset;
    logic        write;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } pcs_cfg_req_t;

  // eeprom sequencer states
  typedef enum logic [1:0] {
    ST_BOOT,
    ST_IDLE,
    ST_PD_READ,
    ST_PD_WRITE
  } pcs_state_t;

endpackage : pcs_pkg

// file: hw/pcs_config_space.sv
// pcs_config_space: config header of the video-port master function
// assumes config requests and path/master status on the pci clock domain
//
// Notes on behaviour
// [R1] master counts clocks to latency value, ends transfer once grant drops
// [R2] header type byte reads multifunction code, self-test byte reads zero
// [R3] base address keeps upper byte only, lower 24 bits read zero
// [R4] board codes load from eeprom bytes 4..7 after reset
// [R5] board code writes take effect only while write enable bit is set
// [R6] capability pointer reads product-data offset, upper bits zero
// [R7] max latency reads all ones, min grant reads six
// [R8] interrupt pin reads one, interrupt line is plain read-write
// [R9] function 1..4 enables load from eeprom at reset release
// [R10] function 0 enable is fixed at one, writes ignored
// [R11] per-path ready is zero while busy, accesses then get retry
// [R12] ready-logic off holds ready at one and drops retry for that path
// [R13] dma arbiter switches channel after selected retry count, default three
// [R14] one control bit turns on host compatibility mode, default off
// [R15] flag 0 starts read, 1 starts write; read sets, write clears flag
// [R16] product-data address is 15-bit byte address in bits 30..16
// [R17] each product-data transfer moves four bytes, low byte at address
// [R18] capability ids and next pointers chain product data then power
// [R19] power capability word reports fixed version and support bits
// [R20] power state accepts D0 and D3hot only, D1/D2 writes ignored
// [R21] unsupported power fields read zero and ignore writes
// [R22] cache line size is a plain read-write byte
// [R23] responds only to type 0 config cycles for function three
// [R24] reserved bits read zero and ignore writes
`timescale 1ns/10ps
module pcs_config_space
  import pcs_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  // configuration access
  input  wire pcs_cfg_req_t cfg_req_i,
  output logic              cfg_ack_o,
  output logic [31:0]       cfg_rdata_o,
  // bus master latency
  input  wire logic         master_active_i,
  input  wire logic         grant_i,
  output logic              master_terminate_o,
  // transfer paths
  input  wire logic [4:0]   path_busy_i,
  input  wire logic [4:0]   path_access_i,
  output logic [4:0]        path_retry_o,
  // dma arbiter
  input  wire logic         dma_retry_i,
  output logic              dma_channel_o,
  // eeprom byte port
  output logic              ee_req_o,
  output logic              ee_write_o,
  output logic [14:0]       ee_addr_o,
  output logic [7:0]        ee_wdata_o,
  input  wire logic         ee_ack_i,
  input  wire logic [7:0]   ee_rdata_i,
  // function controls
  output logic [4:0]        function_enable_o,
  output logic              host_compat_mode_o,
  output logic [1:0]        power_state_o
);

  // storage
  logic [7:0]  cache_line_bytes_q;
  logic [7:0]  master_latency_count_q;
  logic [7:0]  window_base_high_q;
  logic [15:0] board_product_code_q;
  logic [15:0] board_maker_code_q;
  logic [7:0]  int_line_q;
  logic [3:0]  func_en_q;
  logic [4:0]  ready_logic_on_q;
  logic [2:0]  arbiter_retry_limit_q;
  logic        host_compat_q;
  logic        board_code_write_enable_q;
  logic        product_data_done_flag_q;
  logic [14:0] product_data_byte_addr_q;
  logic [31:0] product_data_word_value_q;
  logic [1:0]  power_state_field_q;
  pcs_state_t  state_q;
  logic [2:0]  idx_q;
  logic        req_q;
  logic        write_q;
  logic [14:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  lat_cnt_q;
  logic        active_q;
  logic        term_q;
  logic [2:0]  retry_cnt_q;
  logic        channel_q;
  logic [4:0]  retry_q;
  logic        ack_q;
  logic [31:0] rdata_q;

  // merge written bytes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // decode of a write hitting this function
  logic        hit;
  logic        wr;
  logic [31:0] line_wv;
  logic [31:0] board_wv;
  logic [4:0]  ready_flags;
  logic        byte_done;
  logic        pd_go;
  assign hit = cfg_req_i.valid && cfg_req_i.type0
               && (cfg_req_i.func == FUNC_NUMBER); // R23
  assign wr  = hit && cfg_req_i.write;
  assign byte_done = req_q && ee_ack_i;
  assign pd_go = wr && (cfg_req_i.offset == OFS_PD_CAP)
                 && cfg_req_i.byte_en[3] && (state_q == ST_IDLE);
  // ready reads zero only while busy and its logic is on
  assign ready_flags = ~(path_busy_i & ready_logic_on_q); // R11 R12
  // written words with byte lanes merged over the stored fields
  assign line_wv  = merge({16'h0000, master_latency_count_q,
                           cache_line_bytes_q},
                          cfg_req_i.wdata, cfg_req_i.byte_en);
  assign board_wv = merge({board_product_code_q, board_maker_code_q},
                          cfg_req_i.wdata, cfg_req_i.byte_en);

  // plain software fields
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cache_line_bytes_q     <= 8'h00;
      master_latency_count_q <= 8'h00;
      window_base_high_q     <= 8'h00;
      int_line_q             <= 8'h00;
      power_state_field_q    <= PWR_D0;
    end else if (wr) begin
      if (cfg_req_i.offset == OFS_LINE_LAT) begin
        cache_line_bytes_q     <= line_wv[7:0];   // R22
        master_latency_count_q <= line_wv[15:8];  // R1
      end
      if (cfg_req_i.offset == OFS_BASE0 && cfg_req_i.byte_en[3]) begin
        window_base_high_q <= cfg_req_i.wdata[31:24]; // R3
      end
      if (cfg_req_i.offset == OFS_INT_LAT && cfg_req_i.byte_en[0]) begin
        int_line_q <= cfg_req_i.wdata[7:0]; // R8
      end
      if (cfg_req_i.offset == OFS_PWR_CTRL && cfg_req_i.byte_en[0]
          && (cfg_req_i.wdata[1:0] == PWR_D0
              || cfg_req_i.wdata[1:0] == PWR_D3HOT)) begin
        power_state_field_q <= cfg_req_i.wdata[1:0]; // R20 R21
      end
    end
  end

  // device control fields
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ready_logic_on_q          <= READY_ON_RST;
      arbiter_retry_limit_q     <= RETRY_LIMIT_RST;
      host_compat_q             <= 1'b0;
      board_code_write_enable_q <= 1'b0;
    end else if (wr && cfg_req_i.offset == OFS_DEV_CTRL) begin
      if (cfg_req_i.byte_en[1]) begin
        ready_logic_on_q <= cfg_req_i.wdata[12:8]; // R12
      end
      if (cfg_req_i.byte_en[0]) begin
        arbiter_retry_limit_q     <= cfg_req_i.wdata[6:4]; // R13
        host_compat_q             <= cfg_req_i.wdata[3];   // R14
        board_code_write_enable_q <= cfg_req_i.wdata[0];   // R5
      end
    end
  end

  // board codes and function enables, eeprom load then gated writes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      board_product_code_q <= 16'h0000;
      board_maker_code_q   <= 16'h0000;
      func_en_q            <= FUNC_EN_RST;
    end else if (state_q == ST_BOOT && byte_done) begin
      case (idx_q)
        3'd0:    board_maker_code_q[7:0]    <= ee_rdata_i; // R4
        3'd1:    board_maker_code_q[15:8]   <= ee_rdata_i; // R4
        3'd2:    board_product_code_q[7:0]  <= ee_rdata_i; // R4
        3'd3:    board_product_code_q[15:8] <= ee_rdata_i; // R4
        default: func_en_q                  <= ee_rdata_i[3:0]; // R9
      endcase
    end else if (wr) begin
      if (cfg_req_i.offset == OFS_SUBSYS && board_code_write_enable_q) begin
        board_product_code_q <= board_wv[31:16]; // R5
        board_maker_code_q   <= board_wv[15:0];  // R5
      end
      if (cfg_req_i.offset == OFS_DEV_CTRL && cfg_req_i.byte_en[3]) begin
        func_en_q <= cfg_req_i.wdata[28:25]; // R9 R10
      end
    end
  end

  // eeprom byte sequencer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ST_BOOT;
      idx_q   <= 3'd0;
      req_q   <= 1'b0;
      write_q <= 1'b0;
      addr_q  <= 15'h0000;
      wdata_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          idx_q <= 3'd0;
          if (pd_go) begin
            state_q <= cfg_req_i.wdata[31] ? ST_PD_WRITE : ST_PD_READ; // R15
          end
        end
        ST_BOOT, ST_PD_READ, ST_PD_WRITE: begin
          if (!req_q) begin
            req_q   <= 1'b1;
            write_q <= (state_q == ST_PD_WRITE);
            if (state_q == ST_BOOT) begin
              addr_q <= (idx_q == BOOT_LAST_IDX) ? EE_FUNC_ENABLE
                        : EE_BOARD_MAKER + {12'h000, idx_q}; // R4 R9
            end else begin
              addr_q <= product_data_byte_addr_q + {12'h000, idx_q}; // R17
            end
            wdata_q <= product_data_word_value_q[8*idx_q[1:0] +: 8]; // R17
          end else if (ee_ack_i) begin
            req_q <= 1'b0;
            idx_q <= idx_q + 3'd1;
            if (idx_q == ((state_q == ST_BOOT) ? BOOT_LAST_IDX
                                               : WORD_LAST_IDX)) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // product-data address, flag and word
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      product_data_done_flag_q  <= 1'b0;
      product_data_byte_addr_q  <= 15'h0000;
      product_data_word_value_q <= 32'h0000_0000;
    end else begin
      if (pd_go) begin
        product_data_done_flag_q <= cfg_req_i.wdata[31];    // R15
        product_data_byte_addr_q <= cfg_req_i.wdata[30:16]; // R16
      end
      if (state_q == ST_PD_READ && byte_done) begin
        product_data_word_value_q[8*idx_q[1:0] +: 8] <= ee_rdata_i; // R17
        if (idx_q == WORD_LAST_IDX) begin
          product_data_done_flag_q <= 1'b1; // R15
        end
      end
      if (state_q == ST_PD_WRITE && byte_done && idx_q == WORD_LAST_IDX) begin
        product_data_done_flag_q <= 1'b0; // R15
      end
      if (wr && cfg_req_i.offset == OFS_PD_WORD && state_q == ST_IDLE) begin
        product_data_word_value_q <= merge(product_data_word_value_q,
                                           cfg_req_i.wdata,
                                           cfg_req_i.byte_en);
      end
    end
  end

  // latency timer for this function's master
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lat_cnt_q <= 8'h00;
      active_q  <= 1'b0;
      term_q    <= 1'b0;
    end else begin
      active_q <= master_active_i;
      if (master_active_i && !active_q) begin
        lat_cnt_q <= 8'h00;
      end else if (master_active_i
                   && lat_cnt_q != master_latency_count_q) begin
        lat_cnt_q <= lat_cnt_q + 8'h01; // R1
      end
      term_q <= master_active_i && active_q && !grant_i
                && (lat_cnt_q == master_latency_count_q); // R1
    end
  end

  // path retry and dma channel arbiter
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      retry_q     <= 5'b0_0000;
      retry_cnt_q <= 3'd0;
      channel_q   <= 1'b0;
    end else begin
      retry_q <= path_access_i & ~ready_flags; // R11 R12
      if (dma_retry_i) begin
        if (retry_cnt_q + 3'd1 >= arbiter_retry_limit_q) begin
          retry_cnt_q <= 3'd0;
          channel_q   <= ~channel_q; // R13
        end else begin
          retry_cnt_q <= retry_cnt_q + 3'd1;
        end
      end
    end
  end

  // read answer, one cycle after the request
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= hit; // R23
      case (cfg_req_i.offset)
        OFS_LINE_LAT: rdata_q <= {SELF_TEST_CODE, HEADER_LAYOUT,
                       master_latency_count_q, cache_line_bytes_q}; // R2
        OFS_BASE0:    rdata_q <= {window_base_high_q, 24'h00_0000}; // R3
        OFS_SUBSYS:   rdata_q <= {board_product_code_q, board_maker_code_q};
        OFS_FIRST_CAPABILITY_OFFSET:  rdata_q <= {24'h00_0000, FIRST_CAP_OFS}; // R6
        OFS_INT_LAT:  rdata_q <= {MAX_LATENCY_HINT_HINT, MIN_GRANT_HINT,
                                  INT_PIN_CODE, int_line_q}; // R7 R8
        OFS_DEV_CTRL: rdata_q <= {3'b000, func_en_q, 1'b1, 3'b000,
                       ready_flags, 3'b000, ready_logic_on_q, 1'b0,
                       arbiter_retry_limit_q, host_compat_q, 2'b00,
                       board_code_write_enable_q}; // R10 R11 R24
        OFS_PD_CAP:   rdata_q <= {product_data_done_flag_q,
                       product_data_byte_addr_q, PD_NEXT_OFS,
                       PD_CAP_CODE}; // R18
        OFS_PD_WORD:  rdata_q <= product_data_word_value_q;
        OFS_PWR_CAP:  rdata_q <= {10'h000, 1'b1, 2'b00, PWR_SPEC_VER,
                       PWR_NEXT_OFS, PWR_CAP_CODE}; // R18 R19
        OFS_PWR_CTRL: rdata_q <= {30'h0000_0000,
                                  power_state_field_q}; // R21
        default:      rdata_q <= 32'h0000_0000; // R24
      endcase
    end
  end

  // outputs
  assign cfg_ack_o          = ack_q;
  assign cfg_rdata_o        = rdata_q;
  assign master_terminate_o = term_q;
  assign path_retry_o       = retry_q;
  assign dma_channel_o      = channel_q;
  assign ee_req_o           = req_q;
  assign ee_write_o         = write_q;
  assign ee_addr_o          = addr_q;
  assign ee_wdata_o         = wdata_q;
  assign function_enable_o  = {func_en_q, 1'b1};
  assign host_compat_mode_o = host_compat_q;
  assign power_state_o      = power_state_field_q;

  // checks
  a_ack_only_hit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cfg_ack_o |-> $past(hit)) else $error("ack without matching cycle"); // R23
  a_header_bytes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (hit && cfg_req_i.offset == OFS_LINE_LAT)
    |=> cfg_rdata_o[31:16] == 16'h0080)
    else $error("header byte wrong"); // R2
  a_base_low_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (hit && cfg_req_i.offset == OFS_BASE0)
    |=> cfg_rdata_o[23:0] == 24'h00_0000)
    else $error("base low bits not zero"); // R3
  a_board_locked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_q == ST_IDLE && !board_code_write_enable_q)
    |=> $stable(board_product_code_q)) else $error("board code changed"); // R5
  a_func_zero_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    function_enable_o[0]) else $error("function zero disabled"); // R10
  a_retry_busy: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (path_access_i[2] && path_busy_i[2] && ready_logic_on_q[2])
    |=> path_retry_o[2]) else $error("busy path not retried"); // R11
  a_no_retry_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ready_logic_on_q[2] |=> !path_retry_o[2])
    else $error("retry with ready logic off"); // R12
  a_power_legal: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    power_state_o != 2'b01 && power_state_o != 2'b10)
    else $error("illegal power state"); // R20
  a_term_grant: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    master_terminate_o |-> $past(!grant_i && master_active_i))
    else $error("terminate while granted"); // R1
  a_read_sets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_q == ST_PD_READ && byte_done && idx_q == 3'd3)
    |=> product_data_done_flag_q && state_q == ST_IDLE)
    else $error("read did not set flag"); // R15
  a_switch_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $changed(dma_channel_o) |-> $past(dma_retry_i))
    else $error("channel switch without retry"); // R13

endmodule : pcs_config_space

// file: tb/pcs_ee_model.sv
// pcs_ee_model: byte-wide eeprom on the config block's eeprom port
// assumes one clock; answers each held request after wait_i idle cycles
`timescale 1ns/10ps
module pcs_ee_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // byte port
  input  wire logic        ee_req_i,
  input  wire logic        ee_write_i,
  input  wire logic [14:0] ee_addr_i,
  input  wire logic [7:0]  ee_wdata_i,
  input  wire logic [3:0]  wait_i,
  output logic             ee_ack_o,
  output logic [7:0]       ee_rdata_o
);
  logic [7:0] mem [64];
  logic [3:0] cnt_q;
  // preload: byte n holds 8'h30 + n, function-enable byte is mixed
  initial begin
    for (int n = 0; n < 64; n++) begin
      mem[n] = 8'h30 + 8'(n);
    end
    mem[8] = 8'h0A;
  end
  // data toggles outside an answer so a stale byte never looks valid
  always @(posedge ref_clk_i) begin
    ee_ack_o   <= 1'b0;
    ee_rdata_o <= ~ee_rdata_o;
    if (rst_i) begin
      cnt_q      <= 4'h0;
      ee_rdata_o <= 8'h00;
    end else if (ee_req_i && !ee_ack_o) begin
      if (cnt_q >= wait_i) begin
        ee_ack_o   <= 1'b1;
        cnt_q      <= 4'h0;
        ee_rdata_o <= mem[ee_addr_i[5:0]];
        if (ee_write_i) begin
          mem[ee_addr_i[5:0]] = ee_wdata_i;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule : pcs_ee_model

// file: tb/tb.sv
// tb: self-checking bench for the function-three config header block
// assumes pcs_pkg, pcs_config_space and the eeprom model pcs_ee_model
`timescale 1ns/10ps
module tb;
  import pcs_pkg::*;
  // design and model connections
  logic         ref_clk_i, rst_i, ack, active, grant, term;
  logic         dma_retry, dma_ch, ee_req, ee_wr, ee_ack, compat;
  logic [31:0]  rdata, r;
  logic [4:0]   busy, access, retry, fen;
  logic [14:0]  ee_addr;
  logic [7:0]   ee_wd, ee_rd;
  logic [3:0]   ee_wait;
  logic [1:0]   pstate;
  pcs_cfg_req_t req;
  int           err_total, comparisons, cycles;
  // register table: offset, value written, value read back
  logic [7:0]  t_ofs [7] = '{OFS_LINE_LAT, OFS_BASE0, OFS_FIRST_CAPABILITY_OFFSET,
    OFS_INT_LAT, OFS_PWR_CAP, OFS_PWR_CTRL, 8'h60};
  logic [31:0] t_wd [7] = '{32'hFFFF_1234, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'hFFFF_FF5A, 32'hFFFF_FFFF, 32'hFFFF_FFFC, 32'hFFFF_FFFF};
  logic [31:0] t_ex [7] = '{32'h0080_1234, 32'hFF00_0000, 32'h0000_0044,
    32'hFF06_015A, 32'h0022_0001, 32'h0000_0000, 32'h0000_0000};

  pcs_config_space dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_req_i(req),
    .cfg_ack_o(ack), .cfg_rdata_o(rdata), .master_active_i(active),
    .grant_i(grant), .master_terminate_o(term), .path_busy_i(busy),
    .path_access_i(access), .path_retry_o(retry),
    .dma_retry_i(dma_retry), .dma_channel_o(dma_ch), .ee_req_o(ee_req),
    .ee_write_o(ee_wr), .ee_addr_o(ee_addr), .ee_wdata_o(ee_wd),
    .ee_ack_i(ee_ack), .ee_rdata_i(ee_rd), .function_enable_o(fen),
    .host_compat_mode_o(compat), .power_state_o(pstate));

  pcs_ee_model ee (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ee_req_i(ee_req),
    .ee_write_i(ee_wr), .ee_addr_i(ee_addr), .ee_wdata_i(ee_wd),
    .wait_i(ee_wait), .ee_ack_o(ee_ack), .ee_rdata_o(ee_rd));

  // clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // hang guard
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one config access; ack and data are taken one cycle later
  task automatic cfg(input logic [7:0] o, input logic w,
                     input logic [31:0] d);
    req = {1'b1, 1'b1, FUNC_NUMBER, o, w, 4'hF, d};
    @(negedge ref_clk_i);
    req.valid = 1'b0;
    chk({31'h0, ack}, 32'h1);
    r = rdata;
    @(negedge ref_clk_i);
  endtask : cfg

  task automatic rde(input logic [7:0] o, input logic [31:0] exp);
    cfg(o, 1'b0, 32'h0);
    chk(r, exp);
  endtask : rde

  task automatic t_boot;
    int n;
    n = 0;
    for (int i = 0; i < 300 && n < 5; i++) begin
      @(negedge ref_clk_i);
      if (ee_ack === 1'b1) n++;
    end
    repeat (3) @(negedge ref_clk_i);
    chk(32'(n), 32'h5);
    rde(OFS_SUBSYS, 32'h3736_3534);
    rde(OFS_DEV_CTRL, 32'h151F_1F30);
    chk({27'h0, fen}, 32'h15);
    chk({31'h0, compat}, 32'h0);
  endtask : t_boot

  task automatic t_table;
    for (int i = 0; i < 7; i++) begin
      cfg(t_ofs[i], 1'b1, t_wd[i]);
      rde(t_ofs[i], t_ex[i]);
    end
  endtask : t_table

  task automatic t_control;
    cfg(OFS_SUBSYS, 1'b1, 32'h1111_2222);
    rde(OFS_SUBSYS, 32'h3736_3534);
    cfg(OFS_DEV_CTRL, 1'b1, 32'hE0E0_FFBF);
    rde(OFS_DEV_CTRL, 32'h011F_1F39);
    chk({27'h0, fen}, 32'h1);
    chk({31'h0, compat}, 32'h1);
    cfg(OFS_SUBSYS, 1'b1, 32'h1111_2222);
    rde(OFS_SUBSYS, 32'h1111_2222);
  endtask : t_control

  task automatic t_power;
    logic [1:0] wd [4] = '{2'b11, 2'b01, 2'b10, 2'b00};
    logic [1:0] ex [4] = '{2'b11, 2'b11, 2'b11, 2'b00};
    for (int i = 0; i < 4; i++) begin
      cfg(OFS_PWR_CTRL, 1'b1, {30'h3FFF_FFFF, wd[i]});
      rde(OFS_PWR_CTRL, {30'h0, ex[i]});
      chk({30'h0, pstate}, {30'h0, ex[i]});
    end
  endtask : t_power

  // poll the capability word until the done flag reaches lvl
  task automatic poll_flag(input logic lvl);
    for (int i = 0; i < 60; i++) begin
      cfg(OFS_PD_CAP, 1'b0, 32'h0);
      if (r[31] === lvl) break;
    end
  endtask : poll_flag

  task automatic t_product;
    ee_wait = 4'h2;
    cfg(OFS_PD_CAP, 1'b1, 32'h4010_0000);
    poll_flag(1'b1);
    chk(r, 32'hC010_4C03);
    rde(OFS_PD_WORD, 32'h4342_4140);
    ee_wait = 4'h3;
    cfg(OFS_PD_WORD, 1'b1, 32'hDDCC_BBAA);
    cfg(OFS_PD_CAP, 1'b1, 32'h8020_0000);
    poll_flag(1'b0);
    chk(r, 32'h0020_4C03);
    chk({ee.mem[35], ee.mem[34], ee.mem[33], ee.mem[32]},
        32'hDDCC_BBAA);
  endtask : t_product

  task automatic probe(input logic [4:0] exp);
    access = 5'b00100;
    @(negedge ref_clk_i);
    access = 5'b00000;
    chk({27'h0, retry}, {27'h0, exp});
  endtask : probe

  task automatic t_paths;
    busy = 5'b00100;
    probe(5'b00100);
    rde(OFS_DEV_CTRL, 32'h011B_1F39);
    cfg(OFS_DEV_CTRL, 1'b1, 32'h0000_1B39);
    rde(OFS_DEV_CTRL, 32'h011F_1B39);
    probe(5'b00000);
    busy = 5'b00000;
  endtask : t_paths

  task automatic t_dma;
    for (int i = 1; i <= 3; i++) begin
      dma_retry = 1'b1;
      @(negedge ref_clk_i);
      dma_retry = 1'b0;
      @(negedge ref_clk_i);
      chk({31'h0, dma_ch}, {31'h0, i == 3});
    end
  endtask : t_dma

  task automatic t_latency;
    cfg(OFS_LINE_LAT, 1'b1, 32'h0000_0400);
    grant = 1'b1;
    active = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk_i);
      chk({31'h0, term}, 32'h0);
    end
    grant = 1'b0;
    active = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    active = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk({31'h0, term}, 32'h0);
    @(negedge ref_clk_i);
    chk({31'h0, term}, 32'h0);
    for (int i = 0; i < 8 && term !== 1'b1; i++) @(negedge ref_clk_i);
    chk({31'h0, term}, 32'h1);
    active = 1'b0;
  endtask : t_latency

  task automatic t_foreign;
    req = {1'b1, 1'b1, 3'b010, OFS_FIRST_CAPABILITY_OFFSET, 1'b0, 4'hF, 32'h0000_0000};
    @(negedge ref_clk_i);
    req = {1'b1, 1'b0, FUNC_NUMBER, OFS_FIRST_CAPABILITY_OFFSET, 1'b0, 4'hF, 32'h0000_0000};
    chk({31'h0, ack}, 32'h0);
    @(negedge ref_clk_i);
    req.valid = 1'b0;
    chk({31'h0, ack}, 32'h0);
    @(negedge ref_clk_i);
  endtask : t_foreign

  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    rst_i = 1'b1;
    req = '0;
    {active, grant, dma_retry} = 3'b000;
    busy = 5'b00000;
    access = 5'b00000;
    ee_wait = 4'h0;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_boot();
    t_table();
    t_control();
    t_power();
    t_product();
    t_paths();
    t_dma();
    t_latency();
    t_foreign();
    tally_and_finish();
  end
endmodule : tb
